// ===== qdl_pkg.sv
`default_nettype none
package qdl_pkg;

   // word and channel geometry
   localparam int unsigned WORD_BITS = 32;
   localparam int unsigned NUM_CH    = 4;
   localparam int unsigned CODE_BITS = 16;
   localparam int unsigned CNT_BITS  = 6;
   localparam logic [CNT_BITS-1:0] LAST_BIT_IDX = 6'h1F;

   // command word layout, msb first on the wire
   localparam int unsigned CMD_LSB  = 24;
   localparam int unsigned CMD_W    = 4;
   localparam int unsigned CH_LSB   = 20;
   localparam int unsigned CH_W     = 4;
   localparam int unsigned CODE_LSB = 4;

   typedef logic [CMD_W-1:0] qdl_cmd_t;
   localparam qdl_cmd_t CMD_WR_INPUT  = 4'h0;
   localparam qdl_cmd_t CMD_UPDATE    = 4'h1;
   localparam qdl_cmd_t CMD_WR_UPDATE = 4'h2;
   localparam qdl_cmd_t CMD_SET_CLR   = 4'h7;
   localparam logic [CH_W-1:0] CH_ALL = 4'hF;

   // straight binary codes
   localparam logic [CODE_BITS-1:0] CODE_ZERO = 16'h0000;
   localparam logic [CODE_BITS-1:0] CODE_MID  = 16'h8000;
   localparam logic [CODE_BITS-1:0] CODE_FULL = 16'hFFFF;

   localparam logic [1:0] CLR_SEL_ZERO = 2'h0;
   localparam logic [1:0] CLR_SEL_MID  = 2'h1;
   localparam logic [1:0] CLR_SEL_FULL = 2'h2;
   localparam logic [1:0] CLR_SEL_RST  = CLR_SEL_ZERO;

   // pin synchroniser vector
   localparam int unsigned PIN_COUNT = 6;
   localparam int unsigned PIN_FS    = 0;
   localparam int unsigned PIN_SCLK  = 1;
   localparam int unsigned PIN_SDIN  = 2;
   localparam int unsigned PIN_LOAD  = 3;
   localparam int unsigned PIN_CLR   = 4;
   localparam int unsigned PIN_POR   = 5;
   localparam logic [PIN_COUNT-1:0] SYNC_RST = 6'h1B;

   // cycles after reset release before the strap is trusted
   localparam logic [1:0] INIT_WAIT = 2'h3;

   // link timing, binds the host; our sampling rate gives the same limit in cycles
   localparam int unsigned CLK_PERIOD_NS   = 4;
   localparam int unsigned SCLK_MIN_PER_NS = 20;
   localparam int unsigned SCLK_MIN_CYCLES = (SCLK_MIN_PER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // apb map, byte addresses
   localparam int unsigned ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CTRL      = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_CLRCODE   = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_LASTWORD  = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_WORDCNT   = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_ABORTCNT  = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_BADCMDCNT = 8'h18;
   localparam logic [3:0]        PAGE_INPUT     = 4'h2;
   localparam logic [3:0]        PAGE_CONV      = 4'h3;

   localparam int unsigned CTRL_LINK_EN  = 0;
   localparam int unsigned CTRL_SW_LOAD  = 1;
   localparam logic        LINK_EN_RST   = 1'b1;

   localparam int unsigned ST_FRAME  = 0;
   localparam int unsigned ST_CLR    = 1;
   localparam int unsigned ST_LOAD   = 2;
   localparam int unsigned ST_INIT   = 3;
   localparam int unsigned ST_PEND   = 4;

   typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_DONE} qdl_frame_e;

endpackage
`default_nettype wire

// ===== qdl_sync.sv
`timescale 1ns/10ps
`default_nettype none
module qdl_sync
   import qdl_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic [PIN_COUNT-1:0] pins,
   output var  logic [PIN_COUNT-1:0] pins_s
);

   typedef struct packed {
      logic [PIN_COUNT-1:0] s1;
      logic [PIN_COUNT-1:0] s2;
   } qdl_sync_s;

   qdl_sync_s q;
   qdl_sync_s d;

   always_comb
   begin
      d    = q;
      d.s1 = pins;
      d.s2 = q.s1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '{s1: SYNC_RST, s2: SYNC_RST};
      end
      else
      begin
         q <= d;
      end
   end

   assign pins_s = q.s2;

endmodule // qdl_sync
`default_nettype wire

// ===== qdl_frame_rx.sv
`timescale 1ns/10ps
`default_nettype none
module qdl_frame_rx
   import qdl_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 link_en,
   input  wire logic                 fs_n_s,
   input  wire logic                 sclk_s,
   input  wire logic                 sdin_s,
   output var  logic                 word_valid,
   output var  logic [WORD_BITS-1:0] word,
   output var  logic                 abort,
   output var  logic                 active
);

   typedef struct packed {
      qdl_frame_e           state;
      logic                 fs_prev;
      logic                 sclk_prev;
      logic [CNT_BITS-1:0]  cnt;
      logic [WORD_BITS-1:0] shreg;
      logic                 valid;
      logic                 abort;
   } qdl_frame_s;

   qdl_frame_s q;
   qdl_frame_s d;

   always_comb
   begin
      d           = q;
      d.fs_prev   = fs_n_s;
      d.sclk_prev = sclk_s;
      d.valid     = 1'b0;
      d.abort     = 1'b0;
      case (q.state)
         FR_IDLE:
         begin
            if (q.fs_prev && !fs_n_s && link_en)
            begin
               d.state = FR_SHIFT;
               d.cnt   = '0;
            end
         end
         FR_SHIFT:
         begin
            if (fs_n_s)
            begin
               // partial word is never flagged valid; only abort is pulsed
               d.abort = 1'b1;
               d.state = FR_IDLE;
            end
            else if (q.sclk_prev && !sclk_s)
            begin
               d.shreg = {q.shreg[WORD_BITS-2:0], sdin_s};
               d.cnt   = q.cnt + 6'h01;
               if (q.cnt == LAST_BIT_IDX)
               begin
                  d.valid = 1'b1;
                  d.state = FR_DONE;
               end
            end
         end
         FR_DONE:
         begin
            // extra clocks past the word are ignored until frame select rises
            if (fs_n_s)
            begin
               d.state = FR_IDLE;
            end
         end
         default:
         begin
            d.state = FR_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '{state: FR_IDLE, fs_prev: 1'b1, sclk_prev: 1'b1, cnt: '0, shreg: '0, valid: 1'b0, abort: 1'b0};
      end
      else
      begin
         q <= d;
      end
   end

   assign word_valid = q.valid;
   assign word       = q.shreg;
   assign abort      = q.abort;
   assign active     = (q.state != FR_IDLE);

endmodule // qdl_frame_rx
`default_nettype wire

// ===== qdl_top.sv
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module qdl_top
   import qdl_pkg::*;
(
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic [ADDR_W-1:0]             paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [31:0]                   pwdata,
   output var  logic [31:0]                   prdata,
   output var  logic                          pready,
   output var  logic                          pslverr,
   input  wire logic                          frame_sel_n,
   input  wire logic                          sclk,
   input  wire logic                          sdin,
   input  wire logic                          load_strobe_n,
   input  wire logic                          async_clear_n,
   input  wire logic                          por_sel,
   output var  logic [NUM_CH*CODE_BITS-1:0]   dac_codes
);

   typedef struct packed {
      logic                                link_en;
      logic [1:0]                          clr_sel;
      logic [NUM_CH-1:0][CODE_BITS-1:0]    in_regs;
      logic [NUM_CH-1:0][CODE_BITS-1:0]    conv;
      logic [NUM_CH-1:0]                   pend;
      logic                                clr_prev;
      logic [1:0]                          init_cnt;
      logic                                init_done;
      logic [WORD_BITS-1:0]                last_word;
      logic [15:0]                         word_cnt;
      logic [15:0]                         abort_cnt;
      logic [15:0]                         badcmd_cnt;
      logic                                pready;
      logic                                pslverr;
      logic [31:0]                         prdata;
   } qdl_top_s;

   qdl_top_s q;
   qdl_top_s d;

   logic [PIN_COUNT-1:0] pins;
   logic [PIN_COUNT-1:0] pins_s;
   logic                 word_valid;
   logic [WORD_BITS-1:0] word;
   logic                 abort;
   logic                 frame_active;

   assign pins[PIN_FS]   = frame_sel_n;
   assign pins[PIN_SCLK] = sclk;
   assign pins[PIN_SDIN] = sdin;
   assign pins[PIN_LOAD] = load_strobe_n;
   assign pins[PIN_CLR]  = async_clear_n;
   assign pins[PIN_POR]  = por_sel;

   qdl_sync u_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .pins    (pins),
      .pins_s  (pins_s)
   );

   qdl_frame_rx u_rx
   (
      .pclk       (pclk),
      .presetn    (presetn),
      .link_en    (q.link_en),
      .fs_n_s     (pins_s[PIN_FS]),
      .sclk_s     (pins_s[PIN_SCLK]),
      .sdin_s     (pins_s[PIN_SDIN]),
      .word_valid (word_valid),
      .word       (word),
      .abort      (abort),
      .active     (frame_active)
   );

   function automatic logic [CODE_BITS-1:0] clr_value(input logic [1:0] sel);
      logic [CODE_BITS-1:0] v;
      case (sel)
         CLR_SEL_MID:  v = CODE_MID;
         CLR_SEL_FULL: v = CODE_FULL;
         default:      v = CODE_ZERO;
      endcase
      return v;
   endfunction

   logic                 clr_low;
   logic                 load_low;
   logic                 clr_fall;
   logic                 apb_acc;
   logic                 apb_done;
   logic                 addr_hit;
   logic [31:0]          rdata;
   logic [1:0]           widx;
   qdl_cmd_t             cmd;
   logic [CH_W-1:0]      ch;
   logic [CODE_BITS-1:0] code;
   logic [NUM_CH-1:0]    ch_hit;
   logic                 sw_load;

   assign clr_low  = !pins_s[PIN_CLR];
   assign load_low = !pins_s[PIN_LOAD];
   assign clr_fall = q.clr_prev && clr_low;
   assign apb_acc  = psel && penable;
   assign apb_done = apb_acc && q.pready;
   assign widx     = paddr[3:2];
   assign cmd      = word[CMD_LSB +: CMD_W];
   assign ch       = word[CH_LSB +: CH_W];
   assign code     = word[CODE_LSB +: CODE_BITS];

   genvar gc;
   generate
      for (gc = 0; gc < NUM_CH; gc++)
      begin : g_hit
         assign ch_hit[gc] = (ch == CH_ALL) || (ch == CH_W'(gc));
      end
   endgenerate

   // read mux and address decode
   always_comb
   begin
      rdata    = '0;
      addr_hit = 1'b1;
      if (paddr[1:0] != 2'h0)
      begin
         addr_hit = 1'b0;
      end
      else if (paddr[7:4] == PAGE_INPUT)
      begin
         rdata[CODE_BITS-1:0] = q.in_regs[widx];
      end
      else if (paddr[7:4] == PAGE_CONV)
      begin
         rdata[CODE_BITS-1:0] = q.conv[widx];
      end
      else
      begin
         case (paddr)
            ADDR_CTRL:      rdata[CTRL_LINK_EN] = q.link_en;
            ADDR_CLRCODE:   rdata[1:0] = q.clr_sel;
            ADDR_STATUS:
            begin
               rdata[ST_FRAME]              = frame_active;
               rdata[ST_CLR]                = clr_low;
               rdata[ST_LOAD]               = load_low;
               rdata[ST_INIT]               = q.init_done;
               rdata[ST_PEND +: NUM_CH]     = q.pend;
            end
            ADDR_LASTWORD:  rdata = q.last_word;
            ADDR_WORDCNT:   rdata[15:0] = q.word_cnt;
            ADDR_ABORTCNT:  rdata[15:0] = q.abort_cnt;
            ADDR_BADCMDCNT: rdata[15:0] = q.badcmd_cnt;
            default:        addr_hit = 1'b0;
         endcase
      end
   end

   // write-one pulse that acts like a load strobe from software
   assign sw_load = apb_done && pwrite && (paddr == ADDR_CTRL) && pwdata[CTRL_SW_LOAD];

   always_comb
   begin
      d          = q;
      d.clr_prev = !clr_low;
      d.pready   = 1'b0;
      d.pslverr  = 1'b0;

      // apb: answer one cycle into the access phase
      if (apb_acc && !q.pready)
      begin
         d.pready  = 1'b1;
         d.pslverr = !addr_hit;
         d.prdata  = addr_hit ? rdata : 32'h0000_0000;
      end
      if (apb_done && pwrite && !q.pslverr)
      begin
         if (paddr == ADDR_CTRL)
         begin
            d.link_en = pwdata[CTRL_LINK_EN];
         end
         if (paddr == ADDR_CLRCODE)
         begin
            d.clr_sel = pwdata[1:0];
         end
      end

      // strap is read only after the synchroniser has settled
      if (!q.init_done)
      begin
         if (q.init_cnt == INIT_WAIT)
         begin
            d.init_done = 1'b1;
            for (int c = 0; c < NUM_CH; c++)
            begin
               d.in_regs[c] = pins_s[PIN_POR] ? CODE_MID : CODE_ZERO;
               d.conv[c]    = pins_s[PIN_POR] ? CODE_MID : CODE_ZERO;
            end
         end
         else
         begin
            d.init_cnt = q.init_cnt + 2'h1;
         end
      end

      if (abort)
      begin
         d.abort_cnt = q.abort_cnt + 16'h0001;
      end

      // serial command beats a same-cycle apb write to the clear code
      if (word_valid && q.init_done)
      begin
         d.last_word = word;
         d.word_cnt  = q.word_cnt + 16'h0001;
         case (cmd)
            CMD_WR_INPUT, CMD_UPDATE, CMD_WR_UPDATE:
            begin
               for (int c = 0; c < NUM_CH; c++)
               begin
                  if (ch_hit[c])
                  begin
                     if (cmd != CMD_UPDATE)
                     begin
                        d.in_regs[c] = code;
                        d.pend[c]    = 1'b1;
                     end
                     if ((cmd != CMD_WR_INPUT) && !clr_low)
                     begin
                        d.conv[c] = d.in_regs[c];
                        d.pend[c] = 1'b0;
                     end
                  end
               end
            end
            CMD_SET_CLR:
            begin
               d.clr_sel = code[1:0];
            end
            default:
            begin
               d.badcmd_cnt = q.badcmd_cnt + 16'h0001;
            end
         endcase
      end

      // level-sensitive so a pulse and a tied-low strobe both work
      if ((load_low || sw_load) && !clr_low && q.init_done)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (d.pend[c])
            begin
               d.conv[c] = d.in_regs[c];
               d.pend[c] = 1'b0;
            end
         end
      end

      // clear overrides every input, code and pending-flag update in its cycle
      if (clr_fall && q.init_done)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            d.in_regs[c] = clr_value(q.clr_sel);
            d.conv[c]    = clr_value(q.clr_sel);
         end
         d.pend = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q            <= '0;
         q.link_en    <= LINK_EN_RST;
         q.clr_sel    <= CLR_SEL_RST;
         q.clr_prev   <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   assign prdata    = q.prdata;
   assign pready    = q.pready;
   assign pslverr   = q.pslverr;
   assign dac_codes = q.conv;

endmodule // qdl_top
`default_nettype wire

// ===== qdl_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module qdl_chk
   import qdl_pkg::*;
(
   input wire logic                        pclk,
   input wire logic                        presetn,
   input wire logic [ADDR_W-1:0]           paddr,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [31:0]                 pwdata,
   input wire logic [31:0]                 prdata,
   input wire logic                        pready,
   input wire logic                        pslverr,
   input wire logic                        frame_sel_n,
   input wire logic                        sclk,
   input wire logic                        sdin,
   input wire logic                        load_strobe_n,
   input wire logic                        async_clear_n,
   input wire logic                        por_sel,
   input wire logic [NUM_CH*CODE_BITS-1:0] dac_codes
);
   // cycles since reset release; the strap load must have landed before idle checks start
   logic [3:0] up_q;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         up_q <= 4'h0;
      else if (up_q != 4'hF)
         up_q <= up_q + 4'h1;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   ready_pulse_a: assert property (pready |=> !pready) else $error("pready held past one cycle");
   ready_time_a: assert property (psel && penable && !$past(penable) |=> pready) else $error("pready late");
   no_answer_a: assert property (!psel |-> !pready && !pslverr) else $error("answer without select");
   err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error response");
   idle_hold_a:
      assert property ((up_q == 4'hF && load_strobe_n && async_clear_n && frame_sel_n && !psel)[*8]
         |-> $stable(dac_codes)) else $error("codes moved with no cause");
   clear_hold_a:
      assert property ((up_q == 4'hF && !async_clear_n)[*8] |-> $stable(dac_codes))
         else $error("codes moved while clear low");
   clear_load_a:
      assert property (up_q == 4'hF && $fell(async_clear_n)
         |-> ##[2:8] dac_codes == {NUM_CH{dac_codes[CODE_BITS-1:0]}}) else $error("clear not applied");
   por_init_a:
      assert property ($rose(presetn)
         |-> ##[3:8] dac_codes == (por_sel ? {NUM_CH{CODE_MID}} : {NUM_CH{CODE_ZERO}}))
         else $error("power-up code wrong");
endmodule // qdl_chk
bind qdl_top qdl_chk chk (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .frame_sel_n(frame_sel_n), .sclk(sclk), .sdin(sdin), .load_strobe_n(load_strobe_n),
   .async_clear_n(async_clear_n), .por_sel(por_sel), .dac_codes(dac_codes)
);
`default_nettype wire

// ===== qdl_host.sv
`timescale 1ns/10ps
`default_nettype none
module qdl_host
(
   output var logic frame_sel_n,
   output var logic sclk,
   output var logic sdin
);
   // 160 ns link period, far below the 50 MHz ceiling and our 5-cycle sampling limit
   localparam int HALF = 80;
   initial
   begin
      frame_sel_n = 1'b1;
      sclk = 1'b1;
      sdin = 1'b0;
   end
   // clock idles high between frames; a short count aborts the frame
   task automatic send(input logic [31:0] w, input int n);
      #1 frame_sel_n <= 1'b0;
      for (int i = 0; i < n; i++)
      begin
         sdin <= w[31-i];
         #(HALF/2) sclk <= 1'b0;
         #HALF sclk <= 1'b1;
         #(HALF/2);
      end
      frame_sel_n <= 1'b1;
      // released data line must not keep showing the last bit
      sdin <= ~sdin;
      #HALF;
   endtask
endmodule // qdl_host
`default_nettype wire

// ===== qdl_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module qdl_top_tb
   import qdl_pkg::*;
;
   logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic                        load_strobe_n, async_clear_n, por_sel, frame_sel_n, sclk, sdin;
   logic [ADDR_W-1:0]           paddr;
   logic [31:0]                 pwdata, prdata, rd;
   logic [NUM_CH*CODE_BITS-1:0] dac_codes, ex;
   logic [CODE_BITS-1:0]        cc [3];
   int                          errors, compares;

   qdl_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_sel_n(frame_sel_n), .sclk(sclk), .sdin(sdin), .load_strobe_n(load_strobe_n),
      .async_clear_n(async_clear_n), .por_sel(por_sel), .dac_codes(dac_codes));
   qdl_host host (.frame_sel_n(frame_sel_n), .sclk(sclk), .sdin(sdin));

   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic frame(input qdl_cmd_t c, input logic [3:0] ch, input logic [15:0] v, input int n);
      host.send((32'(c) << CMD_LSB) | (32'(ch) << CH_LSB) | (32'(v) << CODE_LSB), n);
      repeat (12) @(posedge pclk);
   endtask

   task automatic do_reset;
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (12) @(posedge pclk);
   endtask

   initial
   begin
      #300000;
      errors++;
      close_out();
   end

   initial
   begin
      errors = 0;
      compares = 0;
      {paddr, psel, penable, pwrite, pwdata} = '0;
      {load_strobe_n, async_clear_n, por_sel, presetn} = 4'hE;
      cc = '{CODE_ZERO, CODE_FULL, CODE_MID};
      do_reset();
      ex = {NUM_CH{CODE_MID}};
      chk(dac_codes, ex);
      apb(1'b0, ADDR_CLRCODE, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk({er, rd}, {1'b1, 32'h0});
      frame(CMD_WR_INPUT, 4'h0, 16'h1234, 32);
      frame(CMD_WR_INPUT, 4'h2, 16'hABCD, 32);
      chk(dac_codes, ex);
      load_strobe_n <= 1'b0;
      repeat (8) @(posedge pclk);
      load_strobe_n <= 1'b1;
      repeat (8) @(posedge pclk);
      ex[15:0] = 16'h1234;
      ex[47:32] = 16'hABCD;
      chk(dac_codes, ex);
      frame(CMD_WR_UPDATE, 4'h1, 16'h5555, 31);
      chk(dac_codes, ex);
      apb(1'b0, ADDR_ABORTCNT, 32'h0);
      chk(rd, 32'h1);
      frame(CMD_WR_UPDATE, 4'h1, 16'h5555, 32);
      ex[31:16] = 16'h5555;
      chk(dac_codes, ex);
      for (int k = 0; k < 3; k++)
      begin
         if (k == 1)
            apb(1'b1, ADDR_CLRCODE, 32'(CLR_SEL_FULL));
         if (k == 2)
            frame(CMD_SET_CLR, 4'h0, 16'(CLR_SEL_MID), 32);
         async_clear_n <= 1'b0;
         repeat (10) @(posedge pclk);
         ex = {NUM_CH{cc[k]}};
         chk(dac_codes, ex);
         if (k == 0)
         begin
            frame(CMD_WR_UPDATE, 4'h3, 16'h7777, 32);
            load_strobe_n <= 1'b0;
            repeat (8) @(posedge pclk);
            load_strobe_n <= 1'b1;
            repeat (8) @(posedge pclk);
            chk(dac_codes, ex);
         end
         async_clear_n <= 1'b1;
         repeat (6) @(posedge pclk);
      end
      load_strobe_n <= 1'b0;
      frame(CMD_WR_INPUT, 4'h0, 16'h0F0F, 32);
      ex[15:0] = 16'h0F0F;
      chk(dac_codes, ex);
      apb(1'b1, ADDR_CTRL, 32'h0);
      frame(CMD_WR_INPUT, 4'h1, 16'h1111, 32);
      chk(dac_codes, ex);
      apb(1'b1, ADDR_CTRL, 32'h1);
      frame(CMD_WR_INPUT, 4'h1, 16'h2222, 32);
      ex[31:16] = 16'h2222;
      chk(dac_codes, ex);
      load_strobe_n <= 1'b1;
      frame(CMD_WR_INPUT, 4'h2, 16'h3C3C, 32);
      chk(dac_codes, ex);
      frame(CMD_UPDATE, 4'h2, 16'h0000, 32);
      ex[47:32] = 16'h3C3C;
      chk(dac_codes, ex);
      frame(4'h5, 4'hF, 16'hFFFF, 32);
      chk(dac_codes, ex);
      frame(CMD_WR_INPUT, 4'h3, 16'hC3C3, 32);
      apb(1'b1, ADDR_CTRL, 32'h0000_0003);
      ex[63:48] = 16'hC3C3;
      chk(dac_codes, ex);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk({er, rd}, {1'b0, 32'h0000_0008});
      apb(1'b0, ADDR_LASTWORD, 32'h0);
      chk(rd, 32'h003C_3C30);
      apb(1'b0, ADDR_WORDCNT, 32'h0);
      chk(rd, 32'h0000_000B);
      apb(1'b0, ADDR_BADCMDCNT, 32'h0);
      chk(rd, 32'h0000_0001);
      apb(1'b0, {PAGE_CONV, 4'h8}, 32'h0);
      chk(rd, 32'h0000_3C3C);
      por_sel <= 1'b0;
      do_reset();
      chk(dac_codes, 64'h0);
      close_out();
   end
endmodule // qdl_top_tb
`default_nettype wire
